//--- src/ibi_pkg.sv
// package for the instrument bus interface controller:
// bus command codes, address limits, reset values and the pin bundle.
// assumes bus lines arrive already in true-is-one sense.
package ibi_pkg;

    // ==========================================================
    // address setting
    localparam logic [4:0] IBI_ADDR_RESET = 5'h10;
    localparam logic [4:0] IBI_ADDR_MAX   = 5'h1E;

    // ==========================================================
    // bus command codes, seven bits, sent with attention true
    localparam logic [6:0] IBI_CMD_GTL    = 7'h01;
    localparam logic [6:0] IBI_CMD_SDC    = 7'h04;
    localparam logic [6:0] IBI_CMD_GET    = 7'h08;
    localparam logic [6:0] IBI_CMD_LLO    = 7'h11;
    localparam logic [6:0] IBI_CMD_DCL    = 7'h14;
    localparam logic [6:0] IBI_CMD_SPE    = 7'h18;
    localparam logic [6:0] IBI_CMD_SPD    = 7'h19;
    localparam logic [6:0] IBI_CMD_UNL    = 7'h3F;
    localparam logic [6:0] IBI_CMD_UNT    = 7'h5F;
    localparam logic [1:0] IBI_GRP_LISTEN = 2'h1;
    localparam logic [1:0] IBI_GRP_TALK   = 2'h2;

    // ==========================================================
    // status byte layout
    localparam int         IBI_STB_RQS    = 6;

    // ==========================================================
    // reset values
    localparam logic [7:0] IBI_BYTE_RESET = 8'h00;

    // ==========================================================
    // pin bundle as seen on the bus, one bit per line
    typedef struct packed {
        logic [7:0] dio;
        logic       atn;
        logic       ifc;
        logic       ren;
        logic       dav;
        logic       nrfd;
        logic       ndac;
        logic       eoi;
    } ibi_bus_t;

    localparam int IBI_BUS_W = $bits(ibi_bus_t);

    // pins this device may pull true; value and enable per line
    typedef struct packed {
        logic [7:0] dio;
        logic       dav;
        logic       nrfd;
        logic       ndac;
        logic       eoi;
    } ibi_drive_t;

endpackage

//--- src/ibi_sync.sv
// two-stage synchroniser for a group of asynchronous inputs.
// assumes the inputs are levels that stay put for several clocks.
`timescale 1ns/10ps
module ibi_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] async_in,
    output      logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // ==========================================================
    // first stage is read only by the second
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

//--- src/ibi_ctrl.sv
// instrument bus interface controller, device end.
// assumes bus lines are resolved outside from the enables below and
// arrive in true-is-one sense; panel and status ports are on ref_clk.
//
// Behaviour
// - address comes out of reset as 16
// - address writes accepted only in 0..30
// - remote only when listen-addressed with remote enable
// - talking allowed in local and remote
// - remote locks panel except local key
// - interface clear gives local, talker and listener idle
// - interface clear keeps settings and data
// - lockout disables local key until go-to-local
// - addressed go-to-local returns to local
// - device clear acts without addressing
// - clear pulses dev_clear, keeps settings
// - selective clear only when listen-addressed
// - trigger only when bus is trigger source
// - serial poll answers status byte once per poll enable, when talk-addressed
// - talker idle on untalk, listen address, clear
// - listener idle on unlisten, talk address, clear
`timescale 1ns/10ps
module ibi_ctrl
    import ibi_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire ibi_bus_t   bus_in,
    output      ibi_drive_t bus_out,
    output      ibi_drive_t bus_oe,
    output      logic       srq_oe,
    input  wire logic       addr_wr_en,
    input  wire logic [4:0] addr_wr_data,
    output      logic [4:0] addr_cur,
    output      logic       addr_reject,
    input  wire logic       local_key,
    input  wire logic       trig_src_bus,
    input  wire logic [7:0] status_byte,
    input  wire logic       service_req,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_eoi,
    input  wire logic       tx_valid,
    output      logic       tx_ready,
    output      logic [7:0] rx_data,
    output      logic       rx_eoi,
    output      logic       rx_valid,
    output      logic       remote_led,
    output      logic       talk_led,
    output      logic       listen_led,
    output      logic       panel_lock,
    output      logic       local_key_lock,
    output      logic       dev_clear,
    output      logic       trigger,
    output      logic       spoll_read
);

    typedef enum logic [0:0] {AH_READY, AH_HOLD} ibi_ah_t;
    typedef enum logic [1:0] {SH_IDLE, SH_SETTLE, SH_VALID} ibi_sh_t;

    ibi_bus_t   bus_s;
    logic [4:0] addr_q;
    logic       remote_q, llo_q, talk_q, listen_q, spoll_q, spoll_sent_q;
    ibi_ah_t    ah_q;
    ibi_sh_t    sh_q;
    logic [7:0] sh_data_q;
    logic       sh_eoi_q, sh_poll_q;
    logic [7:0] byte_q;
    logic       byte_atn_q, byte_eoi_q, take_q;
    logic       cmd_take, is_mla, is_mta, is_other_ta, ah_active;
    logic       sh_load_data, sh_load_poll;
    logic [6:0] cmd;

    // ==========================================================
    // bus inputs cross into ref_clk
    ibi_sync #(.W(IBI_BUS_W)) u_sync (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in (bus_in),
        .sync_out (bus_s)
    );

    // ==========================================================
    // address setting
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            addr_q      <= IBI_ADDR_RESET;
            addr_reject <= 1'b0;
        end else begin
            addr_reject <= addr_wr_en && (addr_wr_data > IBI_ADDR_MAX);
            if (addr_wr_en && (addr_wr_data <= IBI_ADDR_MAX)) begin
                addr_q <= addr_wr_data;
            end
        end
    end

    assign addr_cur = addr_q;

    // ==========================================================
    // acceptor handshake; outside interface clear, commands are always taken, data only when listening
    assign ah_active = bus_s.atn || listen_q;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ah_q       <= AH_READY;
            byte_q     <= IBI_BYTE_RESET;
            byte_atn_q <= 1'b0;
            byte_eoi_q <= 1'b0;
            take_q     <= 1'b0;
        end else begin
            take_q <= 1'b0;
            unique case (ah_q)
                AH_READY: begin
                    if (ah_active && bus_s.dav && !bus_s.ifc) begin
                        byte_q     <= bus_s.dio;
                        byte_atn_q <= bus_s.atn;
                        byte_eoi_q <= bus_s.eoi;
                        take_q     <= 1'b1;
                        ah_q       <= AH_HOLD;
                    end
                end
                AH_HOLD: begin
                    if (!bus_s.dav) begin
                        ah_q <= AH_READY;
                    end
                end
            endcase
        end
    end

    assign cmd         = byte_q[6:0];
    assign cmd_take    = take_q && byte_atn_q;
    assign is_mla      = cmd == {IBI_GRP_LISTEN, addr_q};
    assign is_mta      = cmd == {IBI_GRP_TALK, addr_q};
    assign is_other_ta = (cmd[6:5] == IBI_GRP_TALK) && !is_mta && (cmd != IBI_CMD_UNT);

    // data bytes go straight out; no buffer, the reader must keep up
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rx_data  <= IBI_BYTE_RESET;
            rx_eoi   <= 1'b0;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= take_q && !byte_atn_q;
            if (take_q && !byte_atn_q) begin
                rx_data <= byte_q;
                rx_eoi  <= byte_eoi_q;
            end
        end
    end

    // ==========================================================
    // talker and listener addressing
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            talk_q   <= 1'b0;
            listen_q <= 1'b0;
        end else if (bus_s.ifc) begin
            talk_q   <= 1'b0;
            listen_q <= 1'b0;
        end else if (cmd_take) begin
            if (is_mta) begin
                talk_q   <= 1'b1;
                listen_q <= 1'b0;
            end else if (is_mla) begin
                listen_q <= 1'b1;
                talk_q   <= 1'b0;
            end else if (cmd == IBI_CMD_UNT || is_other_ta) begin
                talk_q <= 1'b0;
            end else if (cmd == IBI_CMD_UNL) begin
                listen_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // remote, local and lockout
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            remote_q <= 1'b0;
            llo_q    <= 1'b0;
        end else if (!bus_s.ren) begin
            remote_q <= 1'b0;
            llo_q    <= 1'b0;
        end else if (bus_s.ifc) begin
            remote_q <= 1'b0;
        end else if (cmd_take && is_mla) begin
            remote_q <= 1'b1;
        end else if (cmd_take && cmd == IBI_CMD_GTL && listen_q) begin
            remote_q <= 1'b0;
            llo_q    <= 1'b0;
        end else if (cmd_take && cmd == IBI_CMD_LLO) begin
            llo_q <= 1'b1;
        end else if (local_key && !llo_q) begin
            remote_q <= 1'b0;
        end
    end

    assign remote_led     = remote_q;
    assign talk_led       = talk_q;
    assign listen_led     = listen_q;
    assign panel_lock     = remote_q || llo_q;
    assign local_key_lock = llo_q;

    // ==========================================================
    // universal and addressed actions; settings and address untouched
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dev_clear <= 1'b0;
            trigger   <= 1'b0;
            spoll_q   <= 1'b0;
        end else begin
            dev_clear <= cmd_take && ((cmd == IBI_CMD_DCL)
                         || (cmd == IBI_CMD_SDC && listen_q));
            trigger   <= cmd_take && cmd == IBI_CMD_GET && listen_q
                         && trig_src_bus;
            if (bus_s.ifc || (cmd_take && cmd == IBI_CMD_SPD)) begin
                spoll_q <= 1'b0;
            end else if (cmd_take && cmd == IBI_CMD_SPE) begin
                spoll_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // source handshake; poll answers one status byte per poll enable
    assign sh_load_poll = talk_q && spoll_q && !spoll_sent_q && !bus_s.atn;
    assign sh_load_data = talk_q && !spoll_q && !bus_s.atn && tx_valid;
    assign tx_ready     = (sh_q == SH_IDLE) && talk_q && !spoll_q && !bus_s.atn;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sh_q         <= SH_IDLE;
            sh_data_q    <= IBI_BYTE_RESET;
            sh_eoi_q     <= 1'b0;
            sh_poll_q    <= 1'b0;
            spoll_sent_q <= 1'b0;
            spoll_read   <= 1'b0;
        end else begin
            spoll_read <= 1'b0;
            if (cmd_take && cmd == IBI_CMD_SPE) begin
                spoll_sent_q <= 1'b0;
            end
            if (bus_s.atn || bus_s.ifc || !talk_q) begin
                sh_q <= SH_IDLE;
            end else begin
                unique case (sh_q)
                    SH_IDLE: begin
                        if (sh_load_poll) begin
                            sh_data_q <= status_byte;
                            sh_data_q[IBI_STB_RQS] <= service_req;
                            sh_eoi_q  <= 1'b0;
                            sh_poll_q <= 1'b1;
                            sh_q      <= SH_SETTLE;
                        end else if (sh_load_data) begin
                            sh_data_q <= tx_data;
                            sh_eoi_q  <= tx_eoi;
                            sh_poll_q <= 1'b0;
                            sh_q      <= SH_SETTLE;
                        end
                    end
                    SH_SETTLE: begin
                        if (!bus_s.nrfd) begin
                            sh_q <= SH_VALID;
                        end
                    end
                    SH_VALID: begin
                        if (!bus_s.ndac) begin
                            sh_q <= SH_IDLE;
                            if (sh_poll_q) begin
                                spoll_sent_q <= 1'b1;
                                spoll_read   <= 1'b1;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // pin drive; every driven line is pulled true
    always_comb begin
        bus_out      = '0;
        bus_oe       = '0;
        bus_out.dio  = sh_data_q;
        bus_oe.dio   = (sh_q != SH_IDLE) ? sh_data_q : 8'h00;
        bus_out.dav  = 1'b1;
        bus_oe.dav   = sh_q == SH_VALID;
        bus_out.eoi  = 1'b1;
        bus_oe.eoi   = (sh_q != SH_IDLE) && sh_eoi_q;
        bus_out.nrfd = 1'b1;
        bus_oe.nrfd  = ah_active && ah_q == AH_HOLD;
        bus_out.ndac = 1'b1;
        bus_oe.ndac  = ah_active && ah_q == AH_READY;
    end

    assign srq_oe = service_req && !spoll_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    chk_addr_range: assert property (
        addr_wr_en && addr_wr_data > IBI_ADDR_MAX |=> $stable(addr_q) && addr_reject)
        else $error("out of range address stored");
    chk_addr_take: assert property (
        addr_wr_en && addr_wr_data <= IBI_ADDR_MAX |=> addr_q == $past(addr_wr_data))
        else $error("valid address not stored");
    chk_remote_cause: assert property (
        $rose(remote_q) |-> $past(cmd_take && is_mla && bus_s.ren))
        else $error("remote without listen address");
    chk_ifc_idle: assert property (
        bus_s.ifc |=> !talk_q && !listen_q && !remote_q)
        else $error("interface clear left an active state");
    chk_ifc_keeps: assert property (
        bus_s.ifc && !addr_wr_en |=> $stable(addr_q))
        else $error("interface clear changed address");
    chk_panel_lock: assert property (
        remote_q |-> panel_lock) else $error("panel live in remote");
    chk_llo_key: assert property (
        llo_q && local_key && bus_s.ren && !cmd_take && !bus_s.ifc |=> remote_q == $past(remote_q))
        else $error("local key acted under lockout");
    chk_gtl_local: assert property (
        cmd_take && cmd == IBI_CMD_GTL && listen_q |=> !remote_q ##1 !panel_lock || remote_q)
        else $error("go to local ignored");
    chk_dcl_any: assert property (
        cmd_take && cmd == IBI_CMD_DCL |=> dev_clear ##1 !dev_clear || $past(cmd_take))
        else $error("device clear missed");
    chk_sdc_addr: assert property (
        cmd_take && cmd == IBI_CMD_SDC && !listen_q |=> !dev_clear)
        else $error("selective clear while unaddressed");
    chk_get_src: assert property (
        trigger |-> $past(cmd_take && cmd == IBI_CMD_GET && listen_q && trig_src_bus))
        else $error("trigger without bus source");
    chk_talk_drop: assert property (
        cmd_take && (cmd == IBI_CMD_UNT || is_mla) && !bus_s.ifc |=> !talk_q)
        else $error("talker kept active");
    chk_listen_drop: assert property (
        cmd_take && (cmd == IBI_CMD_UNL || is_mta) && !bus_s.ifc |=> !listen_q)
        else $error("listener kept active");
    chk_poll_byte: assert property (
        sh_q == SH_IDLE && sh_load_poll && !bus_s.ifc
        |=> sh_q == SH_SETTLE && sh_data_q[IBI_STB_RQS] == $past(service_req))
        else $error("poll byte not loaded");

    cov_remote:  cover property ($rose(remote_q));
    cov_poll:    cover property (spoll_read);
    cov_trigger: cover property (trigger);
    cov_clear:   cover property (dev_clear && listen_q);

endmodule

//--- verif/ibi_host.sv
// bus controller model: sends bytes with or without attention, reads talker bytes.
// assumes the device's pulls are merged here by wired-or with our own.
`timescale 1ns/10ps
module ibi_host
    import ibi_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire ibi_drive_t dev_out,
    input  wire ibi_drive_t dev_oe,
    output      ibi_bus_t   bus
);
    // ==========================================================
    // wired-or; released lines read false through the pull-ups
    ibi_bus_t   c;
    ibi_drive_t d;
    int         tmo;
    assign d   = dev_out & dev_oe;
    assign bus = c | {d.dio, 3'h0, d.dav, d.nrfd, d.ndac, d.eoi};
    initial begin
        c      = '0;
        c.nrfd = 1'b1;
        c.ndac = 1'b1;
        tmo    = 0;
    end

    // ==========================================================
    // bounded wait on one bus bit; a miss is left for the bench
    task automatic wt(input int i, input logic v);
        int n;
        for (n = 0; n < 400 && bus[i] !== v; n++) begin
            @(posedge ref_clk);
        end
        if (bus[i] !== v) begin
            tmo++;
        end
    endtask

    // source side: byte settles before dav, dav held until accepted
    task automatic send(input logic a, input logic [7:0] b);
        @(posedge ref_clk);
        c.nrfd <= 1'b0;
        c.ndac <= 1'b0;
        c.atn  <= a;
        c.dio  <= b;
        repeat (4) @(posedge ref_clk);
        wt(2, 1'b0);
        c.dav <= 1'b1;
        @(posedge ref_clk);
        wt(1, 1'b0);
        c.dav <= 1'b0;
        repeat (4) @(posedge ref_clk);
        c.atn  <= 1'b0;
        c.dio  <= 8'h00;
        c.nrfd <= 1'b1;
        c.ndac <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask

    // acceptor side; nrfd stays true outside reads and sends so no byte is lost
    task automatic rd(output logic [8:0] r);
        c.nrfd <= 1'b0;
        wt(3, 1'b1);
        r = {bus.eoi, bus.dio};
        c.ndac <= 1'b0;
        c.nrfd <= 1'b1;
        wt(3, 1'b0);
        c.ndac <= 1'b1;
    endtask

    task automatic clr();
        c.ifc <= 1'b1;
        repeat (2000) @(posedge ref_clk);
        c.ifc <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic ren(input logic v);
        c.ren <= v;
        repeat (4) @(posedge ref_clk);
    endtask
endmodule

//--- verif/instrument_bus_interface_ctrl_tb.sv
// self-checking bench for the bus interface controller, device end.
// assumes ibi_host stands in for the bus controller on the far side.
`timescale 1ns/10ps
module instrument_bus_interface_ctrl_tb
    import ibi_pkg::*;
;
    // ==========================================================
    // signals; device at 16, controller elsewhere on the bus
    localparam logic [6:0] MY_LSN = {IBI_GRP_LISTEN, 5'h10};
    localparam logic [6:0] MY_TLK = {IBI_GRP_TALK, 5'h10};
    logic       ref_clk = 1'b0, resetn = 1'b0;
    ibi_bus_t   bus;
    ibi_drive_t bus_out, bus_oe;
    logic       srq_oe, addr_reject, tx_ready, rx_eoi, rx_valid;
    logic       remote_led, talk_led, listen_led, panel_lock, local_key_lock;
    logic       dev_clear, trigger, spoll_read;
    logic       addr_wr_en = 1'b0, local_key = 1'b0, trig_src_bus = 1'b0;
    logic       service_req = 1'b0, tx_eoi = 1'b0, tx_valid = 1'b0;
    logic [4:0] addr_wr_data = 5'h00, addr_cur;
    logic [7:0] status_byte = 8'h00, tx_data = 8'h00, rx_data;
    logic [7:0] n_clr = 8'h00, n_trig = 8'h00, n_sp = 8'h00, n_rx = 8'h00;
    int         bad_count = 0, num_checks = 0;

    always #25 ref_clk = ~ref_clk;

    ibi_ctrl i_ibi_ctrl (
        .ref_clk, .resetn, .bus_in(bus), .bus_out, .bus_oe, .srq_oe,
        .addr_wr_en, .addr_wr_data, .addr_cur, .addr_reject, .local_key,
        .trig_src_bus, .status_byte, .service_req, .tx_data, .tx_eoi,
        .tx_valid, .tx_ready, .rx_data, .rx_eoi, .rx_valid, .remote_led,
        .talk_led, .listen_led, .panel_lock, .local_key_lock, .dev_clear,
        .trigger, .spoll_read
    );
    ibi_host i_ibi_host (.ref_clk, .dev_out(bus_out), .dev_oe(bus_oe), .bus);

    // pulses are counted so a check can ask how many came
    always @(posedge ref_clk) begin
        n_clr  <= n_clr + 8'(dev_clear === 1'b1);
        n_trig <= n_trig + 8'(trigger === 1'b1);
        n_sp   <= n_sp + 8'(spoll_read === 1'b1);
        n_rx   <= n_rx + 8'(rx_valid === 1'b1);
    end

    // ==========================================================
    // shared tasks
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        num_checks++;
        if (g !== e) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
            bad_count++;
        end
        if (i_ibi_host.tmo != 0) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, i_ibi_host.tmo, 0);
            bad_count++;
            print_verdict();
        end
    endtask

    task automatic cmd(input logic [6:0] k);
        i_ibi_host.send(1'b1, {1'b0, k});
    endtask

    task automatic wr(input logic [4:0] v, output logic rj);
        @(posedge ref_clk);
        addr_wr_en   <= 1'b1;
        addr_wr_data <= v;
        @(posedge ref_clk);
        addr_wr_en <= 1'b0;
        #1;
        rj = addr_reject;
    endtask

    task automatic key();
        @(posedge ref_clk);
        local_key <= 1'b1;
        repeat (3) @(posedge ref_clk);
        local_key <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_addr();
        logic rj;
        chk(addr_cur, 9'h010);
        chk({remote_led, talk_led, listen_led, dev_clear, trigger}, 9'h000);
        wr(5'h1E, rj);
        chk({rj, addr_cur}, 9'h01E);
        wr(5'h1F, rj);
        chk({rj, addr_cur}, 9'h03E);
        wr(5'h00, rj);
        chk({rj, addr_cur}, 9'h000);
        wr(5'h10, rj);
        chk(addr_cur, 9'h010);
    endtask

    task automatic t_remote();
        logic [7:0] n0;
        i_ibi_host.ren(1'b1);
        chk(remote_led, 1'b0);
        cmd(MY_LSN);
        chk({remote_led, listen_led, panel_lock}, 9'h007);
        n0 = n_rx;
        i_ibi_host.send(1'b0, 8'h3C);
        chk({rx_eoi, rx_data}, 9'h03C);
        chk(n_rx - n0, 9'h001);
        key();
        chk({remote_led, panel_lock}, 9'h000);
    endtask

    task automatic t_llo();
        cmd(MY_LSN);
        cmd(IBI_CMD_LLO);
        key();
        chk({remote_led, panel_lock, local_key_lock}, 9'h007);
        cmd(IBI_CMD_GTL);
        chk({remote_led, panel_lock, local_key_lock}, 9'h000);
    endtask

    task automatic t_talk();
        logic [8:0] r;
        int         n;
        cmd(MY_TLK);
        chk({remote_led, talk_led, listen_led}, 9'h002);
        @(posedge ref_clk);
        tx_data  <= 8'hA5;
        tx_eoi   <= 1'b1;
        tx_valid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (tx_ready === 1'b1) break;
        end
        chk(tx_ready, 1'b1);
        if (tx_ready !== 1'b1) print_verdict();
        tx_valid <= 1'b0;
        i_ibi_host.rd(r);
        chk(r, 9'h1A5);
        cmd(MY_LSN);
        chk({talk_led, listen_led}, 9'h001);
        cmd(IBI_CMD_UNL);
        chk(listen_led, 1'b0);
        cmd(MY_TLK);
        cmd(IBI_CMD_UNT);
        chk(talk_led, 1'b0);
        cmd(MY_LSN);
        cmd(MY_TLK);
        chk({remote_led, talk_led, listen_led}, 9'h006);
        i_ibi_host.clr();
        chk({remote_led, talk_led, listen_led}, 9'h000);
        chk(addr_cur, 9'h010);
    endtask

    task automatic t_clear();
        logic [7:0] n0;
        n0 = n_clr;
        cmd(IBI_CMD_DCL);
        chk(n_clr - n0, 9'h001);
        cmd(IBI_CMD_SDC);
        chk(n_clr - n0, 9'h001);
        cmd(MY_LSN);
        cmd(IBI_CMD_SDC);
        chk(n_clr - n0, 9'h002);
        chk(addr_cur, 9'h010);
    endtask

    task automatic t_trig();
        logic [7:0] n0;
        for (int s = 0; s < 2; s++) begin
            @(posedge ref_clk);
            trig_src_bus <= s[0];
            n0 = n_trig;
            cmd(IBI_CMD_UNT);
            cmd(IBI_CMD_UNL);
            cmd(MY_LSN);
            cmd(IBI_CMD_GET);
            chk(n_trig - n0, 9'(s));
        end
    endtask

    // polled bit six follows the request, not the status input
    task automatic t_spoll();
        logic [8:0] r;
        logic [7:0] n0;
        n0 = n_sp;
        for (int p = 0; p < 2; p++) begin
            @(posedge ref_clk);
            status_byte <= p[0] ? 8'h45 : 8'h05;
            service_req <= ~p[0];
            repeat (4) @(posedge ref_clk);
            chk(srq_oe, {8'h00, ~p[0]});
            cmd(IBI_CMD_SPE);
            cmd(MY_TLK);
            i_ibi_host.rd(r);
            chk(r[7:0], {1'b0, ~p[0], 6'h05});
            cmd(IBI_CMD_SPD);
        end
        chk(n_sp - n0, 9'h002);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        t_addr();
        t_remote();
        t_llo();
        t_talk();
        t_clear();
        t_trig();
        t_spoll();
        print_verdict();
    end
endmodule
